// ### design/tlsm_defines.vh
// constants for the transport lane sample mapper
`ifndef TLSM_DEFINES_VH
`define TLSM_DEFINES_VH
`define TLSM_SMP_W 9
`define TLSM_SMP_PER_CH 8
`define TLSM_CH_BUS_W 72
`define TLSM_LANE_W 40
`define TLSM_MAX_LANES 8
`define TLSM_FRAME_W 320
`define TLSM_MODE_W 4
`define TLSM_MODE_RST 4'h2
`define TLSM_MODE_2 4'h2
`define TLSM_MODE_3 4'h3
`define TLSM_MODE_4 4'h4
`define TLSM_MODE_5 4'h5
`define TLSM_MODE_6 4'h6
`define TLSM_MODE_7 4'h7
`define TLSM_MODE_8 4'h8
`define TLSM_MODE_9 4'h9
`define TLSM_MODE_10 4'ha
`define TLSM_BUF_DEPTH 2
`endif

// ### design/tlsm_mapper.v
// transport lane sample mapper: packs channel samples into lane frames
//
// How it works
// (R1) the latched link mode picks octet layout, sample width, lane count and encoding
// (R2) tail and filler bits are zero; samples go out most significant bit first
// (R3) mode 2: one 8-bit sample per 8b10b lane, lanes 0..3 carry channels A..D
// (R4) mode 3: four 9-bit samples plus zero bit each, five octets per lane
// (R5) mode 4: A0 B0 C0 D0, each 9 bits plus three zeros, across 2-octet lanes
// (R6) mode 5: lane 0 A0 then B0, lane 1 C0 then D0, absent zeroed
// (R7) mode 6: A0 A1 B0 B1 C0 C1 D0 D1 in 12-bit slots across 2-octet lanes
// (R8) mode 7: one 8-bit sample per 64b66b lane, lanes 0..3 carry A..D
// (R9) mode 8: two 12-bit containers per lane in a three-octet frame
// (R10) mode 9: two lanes per channel, even lane sample 0, odd lane sample 1
// (R11) mode 10: lane pair per channel, even samples first lane, odd samples second
// (R12) mode change is taken only while the link is disabled, never while running
//
// A sample slot is 9 bits; 8-bit modes use bits [7:0] of the slot.
// Lane word l sits at lane_data[l*40 +: 40], octet 0 in its top byte.
`timescale 1ns/1ns
`include "tlsm_defines.vh"
module tlsm_mapper #(
  parameter NUM_CHAN = 4
) (
  input wire mclk,
  input wire srst,
  input wire link_enable,
  input wire [`TLSM_MODE_W-1:0] link_mode_select,
  input wire in_valid,
  output wire in_ready,
  input wire [`TLSM_CH_BUS_W-1:0] in_chan_a,
  input wire [`TLSM_CH_BUS_W-1:0] in_chan_b,
  input wire [`TLSM_CH_BUS_W-1:0] in_chan_c,
  input wire [`TLSM_CH_BUS_W-1:0] in_chan_d,
  output wire lane_valid,
  input wire lane_ready,
  output wire [`TLSM_FRAME_W-1:0] lane_data,
  output reg [3:0] lane_count_reg,
  output reg [2:0] frame_octets_reg,
  output reg enc_64b66b_reg,
  output reg mode_unsupported_reg,
  output reg link_running_reg
);
  reg [`TLSM_MODE_W-1:0] mode_meta_reg;
  reg [`TLSM_MODE_W-1:0] mode_sync_reg;
  reg en_meta_reg;
  reg en_sync_reg;
  reg [`TLSM_MODE_W-1:0] mode_reg;
  reg [3:0] lane_count_next;
  reg [2:0] frame_octets_next;
  reg [`TLSM_FRAME_W-1:0] frame_next;
  reg [47:0] strm4;
  reg [95:0] strm6;
  wire [4*`TLSM_CH_BUS_W-1:0] all_smp;
  wire [4*`TLSM_CH_BUS_W-1:0] smp_bus;
  genvar g;
  wire buf_in_ready;
  wire push_ok;
  integer l;

  assign all_smp = {in_chan_d, in_chan_c, in_chan_b, in_chan_a};

  // absent channels read as zero so their slots go out as filler
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
      assign smp_bus[g*`TLSM_CH_BUS_W +: `TLSM_CH_BUS_W] =
        (g < NUM_CHAN) ? all_smp[g*`TLSM_CH_BUS_W +: `TLSM_CH_BUS_W] : {`TLSM_CH_BUS_W{1'b0}}; // [R2]
    end
  endgenerate

  // sample n of channel c; the bus is an argument so callers stay sensitive to it
  function [8:0] smp;
    input [4*`TLSM_CH_BUS_W-1:0] bus;
    input [1:0] c;
    input [2:0] n;
    begin
      smp = bus[(c*8+n)*9 +: 9];
    end
  endfunction

  // low eight bits of the same slot, for the 8-bit modes
  function [7:0] smp8;
    input [4*`TLSM_CH_BUS_W-1:0] bus;
    input [1:0] c;
    input [2:0] n;
    begin
      smp8 = bus[(c*8+n)*9 +: 8];
    end
  endfunction

  // two-flop synchronisers for the mode and enable pins
  always @(posedge mclk) begin
    if (srst) begin
      mode_meta_reg <= `TLSM_MODE_RST;
      mode_sync_reg <= `TLSM_MODE_RST;
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end else begin
      mode_meta_reg <= link_mode_select;
      mode_sync_reg <= mode_meta_reg;
      en_meta_reg <= link_enable;
      en_sync_reg <= en_meta_reg;
    end
  end

  // lane count and frame length per mode and part variant
  always @* begin
    lane_count_next = 4'h0;
    frame_octets_next = 3'h0;
    case (mode_sync_reg)
      `TLSM_MODE_2, `TLSM_MODE_7: begin
        lane_count_next = NUM_CHAN[3:0];
        frame_octets_next = 3'h1;
      end
      `TLSM_MODE_3: begin
        lane_count_next = NUM_CHAN[3:0];
        frame_octets_next = 3'h5;
      end
      `TLSM_MODE_4: begin
        lane_count_next = (NUM_CHAN == 4) ? 4'h3 : NUM_CHAN[3:0];
        frame_octets_next = 3'h2;
      end
      `TLSM_MODE_5: begin
        lane_count_next = (NUM_CHAN == 4) ? 4'h2 : 4'h1;
        frame_octets_next = 3'h2;
      end
      `TLSM_MODE_6: begin
        lane_count_next = (NUM_CHAN == 4) ? 4'h6 : ((NUM_CHAN == 2) ? 4'h3 : 4'h2);
        frame_octets_next = 3'h2;
      end
      `TLSM_MODE_8: begin
        lane_count_next = NUM_CHAN[3:0];
        frame_octets_next = 3'h3;
      end
      `TLSM_MODE_9: begin
        lane_count_next = {NUM_CHAN[2:0], 1'b0};
        frame_octets_next = 3'h1;
      end
      `TLSM_MODE_10: begin
        lane_count_next = {NUM_CHAN[2:0], 1'b0};
        frame_octets_next = 3'h5;
      end
      default: begin
        lane_count_next = 4'h0;
        frame_octets_next = 3'h0;
      end
    endcase
  end

  // mode latch: follows the pin only while the link is down
  always @(posedge mclk) begin
    if (srst) begin
      mode_reg <= `TLSM_MODE_RST;
      lane_count_reg <= 4'h0;
      frame_octets_reg <= 3'h0;
      enc_64b66b_reg <= 1'b0;
      mode_unsupported_reg <= 1'b0;
      link_running_reg <= 1'b0;
    end else begin
      link_running_reg <= en_sync_reg;
      if (!en_sync_reg) begin // [R12]
        mode_reg <= mode_sync_reg; // [R1]
        lane_count_reg <= lane_count_next;
        frame_octets_reg <= frame_octets_next;
        enc_64b66b_reg <= (mode_sync_reg >= `TLSM_MODE_4) && (mode_sync_reg <= `TLSM_MODE_8);
        mode_unsupported_reg <= (lane_count_next == 4'h0);
      end
    end
  end

  // contiguous streams for the modes that straddle lane boundaries
  always @* begin
    strm4 = {smp(smp_bus, 2'd0, 3'd0), 3'b000, smp(smp_bus, 2'd1, 3'd0), 3'b000,
             smp(smp_bus, 2'd2, 3'd0), 3'b000, smp(smp_bus, 2'd3, 3'd0), 3'b000}; // [R5] [R2]
    strm6 = {smp(smp_bus, 2'd0, 3'd0), 3'b000, smp(smp_bus, 2'd0, 3'd1), 3'b000,
             smp(smp_bus, 2'd1, 3'd0), 3'b000, smp(smp_bus, 2'd1, 3'd1), 3'b000,
             smp(smp_bus, 2'd2, 3'd0), 3'b000, smp(smp_bus, 2'd2, 3'd1), 3'b000,
             smp(smp_bus, 2'd3, 3'd0), 3'b000, smp(smp_bus, 2'd3, 3'd1), 3'b000}; // [R7] [R2]
  end

  // per-lane frame assembly, msb first, unused octets and lanes zero
  always @* begin
    frame_next = {`TLSM_FRAME_W{1'b0}};
    for (l = 0; l < `TLSM_MAX_LANES; l = l + 1) begin
      if (l < lane_count_reg) begin
        case (mode_reg)
          `TLSM_MODE_2, `TLSM_MODE_7: begin
            frame_next[l*40 +: 40] = {smp8(smp_bus, l[1:0], 3'd0), 32'h0000_0000}; // [R3] [R8]
          end
          `TLSM_MODE_3: begin
            frame_next[l*40 +: 40] = {smp(smp_bus, l[1:0], 3'd0), 1'b0,
                                      smp(smp_bus, l[1:0], 3'd1), 1'b0,
                                      smp(smp_bus, l[1:0], 3'd2), 1'b0,
                                      smp(smp_bus, l[1:0], 3'd3), 1'b0}; // [R4]
          end
          `TLSM_MODE_4: begin
            frame_next[l*40 +: 40] = {strm4[47-16*l -: 16], 24'h00_0000}; // [R5]
          end
          `TLSM_MODE_5: begin
            frame_next[l*40 +: 40] = {smp8(smp_bus, {l[0], 1'b0}, 3'd0), smp8(smp_bus, {l[0], 1'b1}, 3'd0),
                                      24'h00_0000}; // [R6]
          end
          `TLSM_MODE_6: begin
            frame_next[l*40 +: 40] = {strm6[95-16*l -: 16], 24'h00_0000}; // [R7]
          end
          `TLSM_MODE_8: begin
            frame_next[l*40 +: 40] = {smp(smp_bus, l[1:0], 3'd0), 3'b000, smp(smp_bus, l[1:0], 3'd1), 3'b000,
                                      16'h0000}; // [R9]
          end
          `TLSM_MODE_9: begin
            frame_next[l*40 +: 40] = {smp8(smp_bus, l[2:1], {2'b00, l[0]}), 32'h0000_0000}; // [R10]
          end
          `TLSM_MODE_10: begin
            frame_next[l*40 +: 40] = {smp(smp_bus, l[2:1], {2'b00, l[0]}), 1'b0,
                                      smp(smp_bus, l[2:1], {2'b01, l[0]}), 1'b0,
                                      smp(smp_bus, l[2:1], {2'b10, l[0]}), 1'b0,
                                      smp(smp_bus, l[2:1], {2'b11, l[0]}), 1'b0}; // [R11]
          end
          default: begin
            frame_next[l*40 +: 40] = 40'h00_0000_0000;
          end
        endcase
      end
    end
  end

  // frames flow only while running with a supported mode; in an unsupported mode they are taken and dropped, while the link is down they are refused
  assign push_ok = link_running_reg & ~mode_unsupported_reg;
  assign in_ready = link_running_reg & (buf_in_ready | mode_unsupported_reg);

  // buffer toward the link so a receiver stall loses no frame
  tlsm_pair_buf #(
    .WIDTH(`TLSM_FRAME_W),
    .DEPTH(`TLSM_BUF_DEPTH),
    .AW(1)
  ) u_buf (
    .mclk(mclk),
    .srst(srst),
    .in_valid(in_valid & push_ok),
    .in_ready(buf_in_ready),
    .in_data(frame_next),
    .out_valid(lane_valid),
    .out_ready(lane_ready),
    .out_data(lane_data)
  );
endmodule // tlsm_mapper

// ### design/tlsm_pair_buf.v
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ns
module tlsm_pair_buf #(
  parameter WIDTH = 320,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire mclk,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  // honest full and empty from the occupancy count
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage and pointers
  always @(posedge mclk) begin
    if (srst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // tlsm_pair_buf

// ### verif/test_tlsm_mapper.sv
// testbench for the lane mapper
`timescale 1ns/1ns
module test_tlsm_mapper;
  logic mclk, srst, link_enable, in_valid, in_ready, lane_valid, lane_ready, stall;
  logic enc_64b66b_reg, mode_unsupported_reg, link_running_reg;
  logic [3:0] link_mode_select, lane_count_reg;
  logic [2:0] frame_octets_reg;
  logic [71:0] ch[4];
  logic [319:0] lane_data;
  int fails, n_tests;
  int lc[11] = '{0, 0, 4, 4, 3, 2, 6, 4, 4, 8, 8};
  int fo[11] = '{0, 0, 1, 5, 2, 2, 2, 1, 3, 1, 5};
  tlsm_mapper #(.NUM_CHAN(4)) i_tlsm_mapper (.mclk(mclk), .srst(srst), .link_enable(link_enable),
    .link_mode_select(link_mode_select), .in_valid(in_valid), .in_ready(in_ready), .in_chan_a(ch[0]),
    .in_chan_b(ch[1]), .in_chan_c(ch[2]), .in_chan_d(ch[3]), .lane_valid(lane_valid), .lane_ready(lane_ready),
    .lane_data(lane_data), .lane_count_reg(lane_count_reg), .frame_octets_reg(frame_octets_reg),
    .enc_64b66b_reg(enc_64b66b_reg), .mode_unsupported_reg(mode_unsupported_reg),
    .link_running_reg(link_running_reg));
  tlsm_lane_sink i_tlsm_lane_sink (.mclk(mclk), .stall(stall), .lane_valid(lane_valid),
    .lane_ready(lane_ready), .lane_data(lane_data));
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  // helpers: time, samples, expected frame
  task automatic tick(int n); repeat (n) @(posedge mclk); #1; endtask
  task automatic fill(int k);
    for (int c = 0; c < 4; c++) for (int n = 0; n < 8; n++) ch[c][n*9 +: 9] = 9'(k * 97 + c * 61 + n * 23 + 267);
  endtask
  function automatic logic [8:0] s9(int c, int n); return (c < 4) ? ch[c][n*9 +: 9] : 9'h0; endfunction
  function automatic logic [319:0] expf(logic [3:0] m);
    logic [319:0] f;
    logic [127:0] st4, st6;
    int c, j;
    st4 = '0;
    st6 = '0;
    for (c = 0; c < 4; c++) begin
      st4 = {st4[115:0], s9(c, 0), 3'h0};
      st6 = {st6[103:0], s9(c, 0), 3'h0, s9(c, 1), 3'h0};
    end
    st4 = (m == 4'h4) ? st4 << 80 : st6 << 32;
    for (int l = 0; l < 8; l++) begin
      c = l >> 1;
      j = l & 1;
      case (m)
        4'h2, 4'h7: f[l*40 +: 40] = {8'(s9(l, 0)), 32'h0};
        4'h3: f[l*40 +: 40] = {s9(l, 0), 1'b0, s9(l, 1), 1'b0, s9(l, 2), 1'b0, s9(l, 3), 1'b0};
        4'h5: f[l*40 +: 40] = {8'(s9(2 * l, 0)), 8'(s9(2 * l + 1, 0)), 24'h0};
        4'h8: f[l*40 +: 40] = {s9(l, 0), 3'h0, s9(l, 1), 3'h0, 16'h0};
        4'h9: f[l*40 +: 40] = {8'(s9(c, j)), 32'h0};
        4'ha: f[l*40 +: 40] = {s9(c, j), 1'b0, s9(c, j + 2), 1'b0, s9(c, j + 4), 1'b0, s9(c, j + 6), 1'b0};
        default: f[l*40 +: 40] = {st4[127-16*l -: 16], 24'h0};
      endcase
    end
    return f;
  endfunction
  task automatic check(string nm, logic [319:0] seen, logic [319:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // offer the current samples until taken; caller lowers valid
  task automatic send;
    in_valid = 1;
    for (int t = 0; t < 50 && in_ready !== 1'b1; t++) tick(1);
    tick(1);
  endtask
  task automatic expect_q(string nm, logic [319:0] exp);
    for (int t = 0; t < 50 && i_tlsm_lane_sink.q.size() == 0; t++) tick(1);
    check(nm, (i_tlsm_lane_sink.q.size() > 0) ? i_tlsm_lane_sink.q.pop_front() : 'x, exp);
  endtask
  task automatic set_mode(logic [3:0] m);
    link_enable = 0;
    link_mode_select = m;
    tick(5);
    check("status", {lane_count_reg, frame_octets_reg, enc_64b66b_reg, mode_unsupported_reg},
      {4'(lc[m]), 3'(fo[m]), m > 3 && m < 9, m < 2});
    link_enable = 1;
    tick(3);
    check("running", link_running_reg, 1);
  endtask
  task automatic t_unsup;
    set_mode(4'h0);
    fill(1);
    send();
    in_valid = 0;
    tick(3);
    check("dropped", {lane_valid, i_tlsm_lane_sink.q.size() == 0}, 2'b01);
  endtask
  task automatic t_modes;
    for (int m = 2; m < 11; m++) begin
      set_mode(4'(m));
      fill(m);
      send();
      in_valid = 0;
      expect_q("layout", expf(4'(m)));
    end
  endtask
  task automatic t_stall;
    logic [319:0] e[3];
    stall = 1;
    for (int k = 0; k < 3; k++) begin
      fill(k + 20);
      e[k] = expf(4'ha);
      if (k < 2) send();
    end
    check("full_refused", in_ready, 0);
    fork
      send();
      begin tick(6); stall = 0; end
    join
    in_valid = 0;
    for (int k = 0; k < 3; k++) expect_q("stalled_order", e[k]);
  endtask
  task automatic t_freeze;
    link_mode_select = 4'h2;
    tick(6);
    check("frozen_lanes", lane_count_reg, 8);
    fill(7);
    send();
    in_valid = 0;
    expect_q("frozen_map", expf(4'ha));
  endtask
  task automatic results;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #100000;
    fails++;
    results();
  end
  // reset, then the scenarios
  initial begin
    srst = 1;
    link_enable = 0;
    link_mode_select = 4'h2;
    in_valid = 0;
    stall = 0;
    fill(0);
    tick(3);
    srst = 0;
    t_unsup();
    t_modes();
    t_stall();
    t_freeze();
    results();
  end
endmodule // test_tlsm_mapper

// ### verif/tlsm_lane_sink.sv
// lane receiver model: takes frames unless told to stall
`timescale 1ns/1ns
module tlsm_lane_sink (
  input wire mclk,
  input wire stall,
  input wire lane_valid,
  output wire lane_ready,
  input wire [319:0] lane_data
);
  logic [319:0] q[$];
  // ready drops for as long as the bench stalls
  assign lane_ready = !stall;
  // keep every frame taken, in order
  always @(posedge mclk) begin
    if (lane_valid && lane_ready) q.push_back(lane_data);
  end
endmodule // tlsm_lane_sink

// ### verif/tlsm_mapper_monitor.sv
// port assertions for the lane mapper
`timescale 1ns/1ns
module tlsm_mapper_monitor #(
  parameter NUM_CHAN = 4
) (
  input wire mclk,
  input wire srst,
  input wire link_enable,
  input wire [3:0] link_mode_select,
  input wire in_valid,
  input wire in_ready,
  input wire lane_valid,
  input wire lane_ready,
  input wire [319:0] lane_data,
  input wire [3:0] lane_count_reg,
  input wire [2:0] frame_octets_reg,
  input wire enc_64b66b_reg,
  input wire mode_unsupported_reg,
  input wire link_running_reg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // mode held at the pins while the link is down
  sequence s_hold9; !link_enable && link_mode_select == 4'h9; endsequence
  sequence s_hold0; !link_enable && link_mode_select == 4'h0; endsequence
  sequence s_en_rise; $rose(link_enable) ##1 link_enable [*2]; endsequence
  property p_mode9; s_hold9 [*5] |=> lane_count_reg == 2 * NUM_CHAN && frame_octets_reg == 3'h1; endproperty
  a_mode9: assert property (p_mode9) else $error("two lanes per channel not set");
  property p_unsup; s_hold0 [*5] |=> mode_unsupported_reg && lane_count_reg == 4'h0; endproperty
  a_unsup: assert property (p_unsup) else $error("unknown mode not flagged");
  property p_en; s_en_rise |=> link_running_reg; endproperty
  a_en: assert property (p_en) else $error("link not running after enable");
  property p_ready_off; !link_running_reg |-> !in_ready; endproperty
  a_ready_off: assert property (p_ready_off) else $error("ready while link down");
  property p_freeze;
    $past(link_running_reg) && link_running_reg |-> $stable(lane_count_reg) && $stable(enc_64b66b_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("mapping moved while running");
  property p_answer; in_valid && in_ready && !lane_valid && !mode_unsupported_reg |=> lane_valid; endproperty
  a_answer: assert property (p_answer) else $error("taken frame not offered");
  property p_stand; lane_valid && !lane_ready |=> lane_valid && $stable(lane_data); endproperty
  a_stand: assert property (p_stand) else $error("frame changed while stalled");
  property p_drop; mode_unsupported_reg && !lane_valid |=> !lane_valid; endproperty
  a_drop: assert property (p_drop) else $error("frame sent in unknown mode");
  property p_tail8; lane_valid && frame_octets_reg == 3'h1 |-> lane_data[31:0] == 32'h0; endproperty
  a_tail8: assert property (p_tail8) else $error("filler octets not zero");
  property p_oct3; frame_octets_reg == 3'h3 |-> enc_64b66b_reg && lane_count_reg == NUM_CHAN; endproperty
  a_oct3: assert property (p_oct3) else $error("three octet frame setup wrong");
endmodule // tlsm_mapper_monitor
bind tlsm_mapper tlsm_mapper_monitor #(.NUM_CHAN(NUM_CHAN)) i_tlsm_mapper_monitor (.mclk(mclk), .srst(srst),
  .link_enable(link_enable), .link_mode_select(link_mode_select), .in_valid(in_valid), .in_ready(in_ready),
  .lane_valid(lane_valid), .lane_ready(lane_ready), .lane_data(lane_data), .lane_count_reg(lane_count_reg),
  .frame_octets_reg(frame_octets_reg), .enc_64b66b_reg(enc_64b66b_reg),
  .mode_unsupported_reg(mode_unsupported_reg), .link_running_reg(link_running_reg));
